// ===== ovmon_defines.svh
// Constants for the output overvoltage monitor.
// Included by the monitor; holds definitions only.
`ifndef OVMON_DEFINES_SVH
`define OVMON_DEFINES_SVH
`define OVMON_CMD_FAULT_LIMIT 8'h40
`define OVMON_CMD_FAULT_RESP  8'h41
`define OVMON_CMD_WARN_LIMIT  8'h42
`define OVMON_ACT_FIELD       7:6
`define OVMON_RETRY_FIELD     5:3
`define OVMON_DELAY_FIELD     2:0
`define OVMON_ACT_IGNORE      2'h0
`define OVMON_ACT_INVALID     2'h3
`define OVMON_RETRY_LATCH     3'h0
`define OVMON_RETRY_FOREVER   3'h7
`define OVMON_DELAY_ZERO      3'h0
`define OVMON_DELAY_ONE       3'h1
`define OVMON_PCT_SCALE       16'h00c8
`define OVMON_REL_ONE         16'h0200
`define OVMON_OVF_BASE        9'h0d2
`define OVMON_OVF_STEP        9'h005
`define OVMON_OVF_COUNT       5'h0f
`define OVMON_OFF_BASE        9'h0dc
`define OVMON_OFF_STEP        9'h014
`define OVMON_OFF_COUNT       5'h04
`define OVMON_WRN_BASE        9'h0ce
`define OVMON_WRN_STEP        9'h002
`define OVMON_WRN_COUNT       5'h0e
`define OVMON_FAULT_RAW_RST   16'h0280
`define OVMON_FAULT_THR_RST   9'h0fa
`define OVMON_WARN_RAW_RST    16'h0228
`define OVMON_WARN_THR_RST    9'h0d8
`define OVMON_RESP_RST        8'h80
`endif

// ===== ovmon_pkg.sv
// Types shared by the overvoltage monitor and its bench.
// Assumes ovmon_defines.svh is on the include path.
package ovmon_pkg;
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } ovmon_req_t;

  typedef enum logic [2:0] {
    OVMON_RUN, OVMON_HICCUP, OVMON_RISE, OVMON_CONFIRM, OVMON_LATCHED
  } ovmon_state_t;

  typedef struct packed {
    logic byteOvFault;
    logic wordVout;
    logic voutOvFault;
    logic voutOvWarn;
    logic cmlInvalid;
  } ovmon_status_t;
endpackage : ovmon_pkg

// ===== ovmon_fault_monitor.sv
// Output overvoltage monitor: limit commands, fault response, hiccup retry.
// Assumes commands arrive on the link clock domain, everything else on clk.
// Operation
// - Threshold stays relative; target changes keep limit
// - Detection active from reset, even when disabled
// - Unsupported limits round up to next step
// - Enabled fault steps 105 to 140 by 2.5
// - Disabled fault steps 110 to 140 by 10
// - Invalid writes flag status and notify host
// - Fault sets three status bits, notifies host
// - Action: ignore, shutdown-and-retry, or invalid
// - Retry field: latch, count, or forever
// - Hiccup period is multiplier times rise time
// - Quiet confirm window after rise clears restart counter
// - Warning sets vout and warning bits, notifies
// - Warning steps 103 to 116 by 1
`timescale 1ns/100ps
`include "ovmon_defines.svh"

module ovmon_fault_monitor #(
  parameter int CNT_W   = 20,
  parameter int TIMER_W = 24
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   linkClk,
  input  wire logic                   linkRst,
  input  wire logic                   linkReqValid,
  input  wire ovmon_pkg::ovmon_req_t  linkReq,
  output logic                        linkBusy,
  output logic                        linkDone,
  output logic [15:0]                 linkRdData,
  input  wire logic                   convEnable,
  input  wire logic                   voutRelFormat,
  input  wire logic [15:0]            voutTarget,
  input  wire logic [8:0]             voutRatio,
  input  wire logic [CNT_W-1:0]       riseCycles,
  input  wire logic [CNT_W-1:0]       tonMaxCycles,
  input  wire logic                   statusClear,
  output ovmon_pkg::ovmon_status_t    status,
  output logic                        hostNotify,
  output logic                        convShutdown,
  output logic [2:0]                  restartCount
);

  // Refuse a timer too narrow for seven rise times.
  if (TIMER_W < CNT_W + 3) begin : gWidthCheck
    $error("TIMER_W must be at least CNT_W plus 3");
  end

  // Finds the smallest supported step at or above num/den, in half percent.
  function automatic logic [9:0] ovmonRoundUp(
    input logic [15:0] num,
    input logic [15:0] den,
    input logic [8:0]  base,
    input logic [8:0]  step,
    input logic [4:0]  count,
    input logic        lowOk
  );
    logic [25:0] want;
    logic [8:0]  k;
    logic [9:0]  res;
    want = 26'(num) * 26'(`OVMON_PCT_SCALE);
    res  = '0;
    for (int i = 15; i >= 0; i--) begin
      k = 9'(base + 9'(step * 9'(i)));
      if ((5'(i) < count) && (26'(den) * 26'(k) >= want)) begin
        res = {1'b1, k};
      end
    end
    if (!lowOk && (want < 26'(den) * 26'(base))) begin
      res[9] = 1'b0;
    end
    return res;
  endfunction : ovmonRoundUp

  // Link side: request hold, toggle and answer capture.
  ovmon_pkg::ovmon_req_t reqHold_q, reqHold_d;
  logic        reqTgl_q, reqTgl_d;
  logic        linkBusy_q, linkBusy_d;
  logic        linkDone_q, linkDone_d;
  logic [15:0] linkRdData_q, linkRdData_d;
  logic [1:0]  ackSync_q;
  logic        ackSeen_q, ackSeen_d;

  // Core side: handshake, registers and status.
  logic [1:0]  reqSync_q;
  logic        reqSeen_q;
  logic        ackTgl_q, ackTgl_d;
  logic [15:0] rdData_q, rdData_d;
  logic [15:0] faultRaw_q, faultRaw_d;
  logic [8:0]  faultThr_q, faultThr_d;
  logic [7:0]  resp_q, resp_d;
  logic [15:0] warnRaw_q, warnRaw_d;
  logic [8:0]  warnThr_q, warnThr_d;
  ovmon_pkg::ovmon_status_t status_q, status_d;
  logic        hostNotify_q, hostNotify_d;
  logic        ovAbove_q, warnAbove_q;

  // Retry machine.
  ovmon_pkg::ovmon_state_t state_q, state_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  logic [2:0]  restart_q, restart_d;
  logic        convShutdown_q, convShutdown_d;

  logic        newReq;
  logic [15:0] den;
  logic [9:0]  fitFault, fitWarn, gridFit;
  logic [8:0]  effFault;
  logic        ovAbove, warnAbove, ovEvent, warnEvent, cmdBad;
  logic        shutdownGo, mustLatch;
  logic [TIMER_W-1:0] hiccupLen, confirmLen;

  // Link domain next values: accept one request at a time, wait for the ack.
  always_comb begin : linkNext
    reqHold_d    = reqHold_q;
    reqTgl_d     = reqTgl_q;
    linkBusy_d   = linkBusy_q;
    linkDone_d   = 1'b0;
    linkRdData_d = linkRdData_q;
    ackSeen_d    = ackSync_q[1];
    if (linkReqValid && !linkBusy_q) begin
      reqHold_d  = linkReq;
      reqTgl_d   = ~reqTgl_q;
      linkBusy_d = 1'b1;
    end
    if (ackSync_q[1] != ackSeen_q) begin
      linkDone_d   = 1'b1;
      linkRdData_d = rdData_q;
      linkBusy_d   = 1'b0;
    end
  end

  // Link domain registers and ack synchroniser.
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      reqHold_q    <= '0;
      reqTgl_q     <= 1'b0;
      linkBusy_q   <= 1'b0;
      linkDone_q   <= 1'b0;
      linkRdData_q <= '0;
      ackSync_q    <= '0;
      ackSeen_q    <= 1'b0;
    end else begin
      reqHold_q    <= reqHold_d;
      reqTgl_q     <= reqTgl_d;
      linkBusy_q   <= linkBusy_d;
      linkDone_q   <= linkDone_d;
      linkRdData_q <= linkRdData_d;
      ackSync_q    <= {ackSync_q[0], ackTgl_q};
      ackSeen_q    <= ackSeen_d;
    end
  end

  // Limits are fitted against the target seen at write time only.
  assign newReq   = reqSync_q[1] != reqSeen_q;
  assign den      = voutRelFormat ? `OVMON_REL_ONE : voutTarget;
  assign fitFault = ovmonRoundUp(reqHold_q.data, den, `OVMON_OVF_BASE,
                      `OVMON_OVF_STEP, `OVMON_OVF_COUNT, 1'b0);
  assign fitWarn  = ovmonRoundUp(reqHold_q.data, den, `OVMON_WRN_BASE,
                      `OVMON_WRN_STEP, `OVMON_WRN_COUNT, 1'b0);
  assign gridFit  = ovmonRoundUp(16'(faultThr_q), `OVMON_PCT_SCALE,
                      `OVMON_OFF_BASE, `OVMON_OFF_STEP, `OVMON_OFF_COUNT, 1'b1);
  assign effFault = convEnable ? faultThr_q : gridFit[8:0];

  // Comparison runs regardless of conversion state.
  assign ovAbove   = voutRatio > effFault;
  assign warnAbove = voutRatio > warnThr_q;
  assign ovEvent   = ovAbove && !ovAbove_q;
  assign warnEvent = warnAbove && !warnAbove_q;

  // Command decode, register update and sticky status; set beats clear.
  always_comb begin : regNext
    faultRaw_d = faultRaw_q;
    faultThr_d = faultThr_q;
    resp_d     = resp_q;
    warnRaw_d  = warnRaw_q;
    warnThr_d  = warnThr_q;
    rdData_d   = rdData_q;
    ackTgl_d   = ackTgl_q;
    cmdBad     = 1'b0;
    if (newReq) begin
      ackTgl_d = ~ackTgl_q;
      rdData_d = '0;
      unique case (reqHold_q.code)
        `OVMON_CMD_FAULT_LIMIT: begin
          if (!reqHold_q.write) begin
            rdData_d = faultRaw_q;
          end else if (fitFault[9]) begin
            faultRaw_d = reqHold_q.data;
            faultThr_d = fitFault[8:0];
          end else begin
            cmdBad = 1'b1;
          end
        end
        `OVMON_CMD_FAULT_RESP: begin
          if (!reqHold_q.write) begin
            rdData_d = {8'h00, resp_q};
          end else if (reqHold_q.data[`OVMON_ACT_FIELD] != `OVMON_ACT_INVALID) begin
            resp_d = reqHold_q.data[7:0];
          end else begin
            cmdBad = 1'b1;
          end
        end
        `OVMON_CMD_WARN_LIMIT: begin
          if (!reqHold_q.write) begin
            rdData_d = warnRaw_q;
          end else if (fitWarn[9]) begin
            warnRaw_d = reqHold_q.data;
            warnThr_d = fitWarn[8:0];
          end else begin
            cmdBad = 1'b1;
          end
        end
        default: rdData_d = '0;
      endcase
    end
    status_d = statusClear ? '0 : status_q;
    status_d.byteOvFault = status_d.byteOvFault | ovEvent;
    status_d.voutOvFault = status_d.voutOvFault | ovEvent;
    status_d.voutOvWarn  = status_d.voutOvWarn | warnEvent;
    status_d.wordVout    = status_d.wordVout | ovEvent | warnEvent;
    status_d.cmlInvalid  = status_d.cmlInvalid | cmdBad;
    hostNotify_d = ovEvent | warnEvent | cmdBad;
  end

  // Core registers and request synchroniser.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reqSync_q    <= '0;
      reqSeen_q    <= 1'b0;
      ackTgl_q     <= 1'b0;
      rdData_q     <= '0;
      faultRaw_q   <= `OVMON_FAULT_RAW_RST;
      faultThr_q   <= `OVMON_FAULT_THR_RST;
      resp_q       <= `OVMON_RESP_RST;
      warnRaw_q    <= `OVMON_WARN_RAW_RST;
      warnThr_q    <= `OVMON_WARN_THR_RST;
      status_q     <= '0;
      hostNotify_q <= 1'b0;
      ovAbove_q    <= 1'b0;
      warnAbove_q  <= 1'b0;
    end else begin
      reqSync_q    <= {reqSync_q[0], reqTgl_q};
      reqSeen_q    <= reqSync_q[1];
      ackTgl_q     <= ackTgl_d;
      rdData_q     <= rdData_d;
      faultRaw_q   <= faultRaw_d;
      faultThr_q   <= faultThr_d;
      resp_q       <= resp_d;
      warnRaw_q    <= warnRaw_d;
      warnThr_q    <= warnThr_d;
      status_q     <= status_d;
      hostNotify_q <= hostNotify_d;
      ovAbove_q    <= ovAbove;
      warnAbove_q  <= warnAbove;
    end
  end

  // Hiccup length; a multiplier of zero counts as one rise time.
  assign hiccupLen = TIMER_W'(TIMER_W'(riseCycles) * TIMER_W'(
    (resp_q[`OVMON_DELAY_FIELD] == `OVMON_DELAY_ZERO) ?
    `OVMON_DELAY_ONE : resp_q[`OVMON_DELAY_FIELD]));
  assign confirmLen = (tonMaxCycles != '0) ? TIMER_W'(tonMaxCycles)
                                           : TIMER_W'(riseCycles);
  assign shutdownGo = ovEvent && convEnable &&
                      (resp_q[`OVMON_ACT_FIELD] != `OVMON_ACT_IGNORE);
  assign mustLatch  = (resp_q[`OVMON_RETRY_FIELD] == `OVMON_RETRY_LATCH) ||
                      ((resp_q[`OVMON_RETRY_FIELD] != `OVMON_RETRY_FOREVER) &&
                       (restart_q >= resp_q[`OVMON_RETRY_FIELD]));

  // Fault response: shutdown, hiccup wait, restart, confirm or latch off.
  always_comb begin : fsmNext
    state_d   = state_q;
    timer_d   = (timer_q != '0) ? TIMER_W'(timer_q - 1'b1) : timer_q;
    restart_d = restart_q;
    unique case (state_q)
      ovmon_pkg::OVMON_RUN: ;
      ovmon_pkg::OVMON_HICCUP: begin
        if (timer_q == '0) begin
          state_d = ovmon_pkg::OVMON_RISE;
          timer_d = TIMER_W'(riseCycles);
          if (restart_q != `OVMON_RETRY_FOREVER) begin
            restart_d = 3'(restart_q + 1'b1);
          end
        end
      end
      ovmon_pkg::OVMON_RISE: begin
        if (timer_q == '0) begin
          state_d = ovmon_pkg::OVMON_CONFIRM;
          timer_d = confirmLen;
        end
      end
      ovmon_pkg::OVMON_CONFIRM: begin
        if (timer_q == '0) begin
          state_d   = ovmon_pkg::OVMON_RUN;
          restart_d = '0;
        end
      end
      ovmon_pkg::OVMON_LATCHED: ;
    endcase
    if (shutdownGo && (state_q != ovmon_pkg::OVMON_HICCUP) &&
        (state_q != ovmon_pkg::OVMON_LATCHED)) begin
      if (mustLatch) begin
        state_d = ovmon_pkg::OVMON_LATCHED;
      end else begin
        state_d = ovmon_pkg::OVMON_HICCUP;
        timer_d = hiccupLen;
      end
    end
    if (!convEnable) begin
      state_d   = ovmon_pkg::OVMON_RUN;
      timer_d   = '0;
      restart_d = '0;
    end
    convShutdown_d = state_d != ovmon_pkg::OVMON_RUN;
  end

  // Retry machine registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q        <= ovmon_pkg::OVMON_RUN;
      timer_q        <= '0;
      restart_q      <= '0;
      convShutdown_q <= 1'b0;
    end else begin
      state_q        <= state_d;
      timer_q        <= timer_d;
      restart_q      <= restart_d;
      convShutdown_q <= convShutdown_d;
    end
  end

  assign linkBusy     = linkBusy_q;
  assign linkDone     = linkDone_q;
  assign linkRdData   = linkRdData_q;
  assign status       = status_q;
  assign hostNotify   = hostNotify_q;
  assign convShutdown = convShutdown_q;
  assign restartCount = restart_q;

  // Checks on the core clock.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_abs_keep;
    $changed(voutTarget) && !newReq |=> $stable(faultRaw_q) && $stable(faultThr_q);
  endproperty
  a_abs_keep: assert property (p_abs_keep) else $error("limit moved with target");

  property p_off_detect;
    !convEnable && ovEvent |=> status_q.voutOvFault && hostNotify_q;
  endproperty
  a_off_detect: assert property (p_off_detect) else $error("no detect while off");

  property p_round_up;
    newReq && reqHold_q.write && (reqHold_q.code == `OVMON_CMD_FAULT_LIMIT) &&
      fitFault[9] |-> 26'(den) * 26'(fitFault[8:0]) >=
      26'(reqHold_q.data) * 26'(`OVMON_PCT_SCALE);
  endproperty
  a_round_up: assert property (p_round_up) else $error("limit rounded down");

  property p_on_grid;
    convEnable |-> (effFault >= `OVMON_OVF_BASE) && (effFault <= 9'h118) &&
      ((effFault - `OVMON_OVF_BASE) % `OVMON_OVF_STEP == 0);
  endproperty
  a_on_grid: assert property (p_on_grid) else $error("fault step off grid");

  property p_off_grid;
    !convEnable |-> (effFault inside {9'h0dc, 9'h0f0, 9'h104, 9'h118});
  endproperty
  a_off_grid: assert property (p_off_grid) else $error("disabled step wrong");

  property p_bad_resp;
    newReq && reqHold_q.write && (reqHold_q.code == `OVMON_CMD_FAULT_RESP) &&
      (reqHold_q.data[`OVMON_ACT_FIELD] == `OVMON_ACT_INVALID)
      |=> status_q.cmlInvalid && hostNotify_q && $stable(resp_q);
  endproperty
  a_bad_resp: assert property (p_bad_resp) else $error("invalid action taken");

  property p_fault_flags;
    ovEvent |=> status_q.byteOvFault && status_q.wordVout && status_q.voutOvFault
      && hostNotify_q;
  endproperty
  a_fault_flags: assert property (p_fault_flags) else $error("fault flags missing");

  property p_ignore;
    (state_q == ovmon_pkg::OVMON_RUN) && (resp_q[`OVMON_ACT_FIELD] == `OVMON_ACT_IGNORE)
      |=> state_q == ovmon_pkg::OVMON_RUN;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore caused shutdown");

  property p_latch_zero;
    shutdownGo && (resp_q[`OVMON_RETRY_FIELD] == `OVMON_RETRY_LATCH)
      |=> state_q == ovmon_pkg::OVMON_LATCHED && convShutdown_q;
  endproperty
  a_latch_zero: assert property (p_latch_zero) else $error("retry zero not latched");

  property p_hiccup_len;
    (state_q == ovmon_pkg::OVMON_RUN) ##1 (state_q == ovmon_pkg::OVMON_HICCUP)
      |-> timer_q == $past(hiccupLen);
  endproperty
  a_hiccup_len: assert property (p_hiccup_len) else $error("hiccup length wrong");

  property p_success;
    (state_q == ovmon_pkg::OVMON_CONFIRM) && (timer_q == '0) && convEnable && !shutdownGo
      |=> (restart_q == 3'h0) && (state_q == ovmon_pkg::OVMON_RUN);
  endproperty
  a_success: assert property (p_success) else $error("counter not cleared");

  property p_warn_flags;
    warnEvent |=> status_q.wordVout && status_q.voutOvWarn && hostNotify_q;
  endproperty
  a_warn_flags: assert property (p_warn_flags) else $error("warning flags missing");

  property p_warn_grid;
    (warnThr_q >= `OVMON_WRN_BASE) && (warnThr_q <= 9'h0e8) && !warnThr_q[0];
  endproperty
  a_warn_grid: assert property (p_warn_grid) else $error("warning step off grid");

  property p_attempt;
    (state_q == ovmon_pkg::OVMON_HICCUP) && (timer_q == '0) && convEnable &&
      (restart_q != 3'h7) |=> restart_q == 3'($past(restart_q) + 1'b1);
  endproperty
  a_attempt: assert property (p_attempt) else $error("attempt not counted");

endmodule : ovmon_fault_monitor

// ===== ovmon_host_model.sv
// Link-side host model that issues limit and response commands.
// Assumes the monitor answers every accepted request with one linkDone pulse.
`timescale 1ns/100ps
module ovmon_host_model (
  input  wire logic             linkClk,
  input  wire logic             linkBusy,
  input  wire logic             linkDone,
  input  wire logic [15:0]      linkRdData,
  output logic                  linkReqValid,
  output ovmon_pkg::ovmon_req_t linkReq,
  output logic                  hostTimeout
);
  // Idle values at time zero.
  initial begin
    linkReqValid = 1'b0;
    linkReq      = '0;
    hostTimeout  = 1'b0;
  end

  // One transfer; the released bus is scrambled so stale data cannot pass for fresh.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge linkClk);
    linkReqValid <= 1'b1;
    linkReq      <= {wr, code, data};
    @(posedge linkClk);
    linkReqValid <= 1'b0;
    linkReq      <= ~linkReq;
    #1;
    while (linkDone !== 1'b1 && n < 20) begin
      @(posedge linkClk);
      #1;
      n++;
    end
    if (n >= 20) begin
      hostTimeout <= 1'b1;
    end
    rd = linkRdData;
  endtask : xfer
endmodule : ovmon_host_model

// ===== vout_overvoltage_fault_monitor_tb_top.sv
// Self-checking bench for the overvoltage monitor, driven through the host model.
// Assumes the package, the monitor and the host model are compiled before it.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module vout_overvoltage_fault_monitor_tb_top;
  logic                     clk, sys_rst, linkClk, linkRst, linkReqValid;
  logic                     linkBusy, linkDone, convEnable, voutRelFormat;
  logic                     statusClear, hostNotify, convShutdown, hostTimeout;
  logic [15:0]              linkRdData, voutTarget, rd;
  logic [8:0]               voutRatio;
  logic [19:0]              riseCycles, tonMaxCycles;
  logic [2:0]               restartCount;
  ovmon_pkg::ovmon_req_t    linkReq;
  ovmon_pkg::ovmon_status_t status;
  int                       error_cnt, checks_done;

  ovmon_fault_monitor #(.CNT_W(20), .TIMER_W(24)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .linkClk(linkClk), .linkRst(linkRst),
    .linkReqValid(linkReqValid), .linkReq(linkReq), .linkBusy(linkBusy),
    .linkDone(linkDone), .linkRdData(linkRdData), .convEnable(convEnable),
    .voutRelFormat(voutRelFormat), .voutTarget(voutTarget), .voutRatio(voutRatio),
    .riseCycles(riseCycles), .tonMaxCycles(tonMaxCycles), .statusClear(statusClear),
    .status(status), .hostNotify(hostNotify), .convShutdown(convShutdown),
    .restartCount(restartCount));

  ovmon_host_model u_host (
    .linkClk(linkClk), .linkBusy(linkBusy), .linkDone(linkDone),
    .linkRdData(linkRdData), .linkReqValid(linkReqValid), .linkReq(linkReq),
    .hostTimeout(hostTimeout));

  // Core clock at 4 ns and an unrelated 15 ns link clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #3.3;
    forever #7.5 linkClk = ~linkClk;
  end

  // Smallest supported step at or above a raw limit; 0 when out of range.
  function automatic logic [8:0] fitThr(logic [15:0] raw, logic [15:0] den,
                                        int base, int step, int cnt);
    if (raw * 200 < base * den) return 9'h000;
    for (int k = 0; k < cnt; k++) begin
      if ((base + k * step) * den >= raw * 200) return 9'(base + k * step);
    end
    return 9'h000;
  endfunction : fitThr

  // Threshold used while conversion is off: next 10 percent step.
  function automatic logic [8:0] offThr(logic [8:0] thr);
    for (int k = 0; k < 4; k++) begin
      if (220 + 20 * k >= thr) return 9'(220 + 20 * k);
    end
    return 9'h000;
  endfunction : offThr

  task automatic clkN(int n);
    repeat (n) @(posedge clk);
  endtask : clkN

  // Waits for the falling edge, so outputs launched at the rising edge have settled.
  task automatic look();
    @(negedge clk);
  endtask : look

  task automatic clr();
    clkN(1);
    statusClear <= 1'b1;
    clkN(2);
    statusClear <= 1'b0;
    clkN(1);
  endtask : clr

  task automatic rdChk(string nm, logic [7:0] code, logic [15:0] ex);
    u_host.xfer(1'b0, code, 16'h0000, rd);
    `CHK("linkIdle", 1'b0, linkBusy)
    `CHK(nm, ex, rd)
    clkN(1);
  endtask : rdChk

  // No event at the threshold itself, one event just above it.
  task automatic probe(string nm, logic [8:0] thr, bit warn);
    clkN(1);
    voutRatio <= 9'h000;
    clr();
    voutRatio <= thr;
    clkN(4);
    look();
    `CHK(nm, 1'b0, warn ? status.voutOvWarn : status.voutOvFault)
    clkN(1);
    voutRatio <= thr + 9'h001;
    clkN(4);
    look();
    `CHK(nm, 1'b1, warn ? status.voutOvWarn : status.voutOvFault)
    `CHK("wordVout", 1'b1, status.wordVout)
    if (!warn) `CHK("ignoreRun", 1'b0, convShutdown)
    clkN(1);
  endtask : probe

  // Raise the output sharply and check the event response.
  task automatic fire();
    clkN(1);
    voutRatio <= 9'h000;
    clr();
    voutRatio <= 9'h1ff;
    clkN(1);
    look();
    `CHK("notify", 1'b1, hostNotify)
    `CHK("faultBits", 3'h7, {status.byteOvFault, status.wordVout, status.voutOvFault})
    `CHK("shutdown", 1'b1, convShutdown)
    clkN(1);
    voutRatio <= 9'h000;
    look();
    `CHK("notifyPulse", 1'b0, hostNotify)
    clkN(1);
  endtask : fire

  // Fault limit and warning limit sweeps with corner values first.
  task automatic sweep(bit warn);
    logic [15:0] raw, old;
    logic [8:0]  thr;
    logic [15:0] corner [4];
    if (warn) begin
      corner = '{16'h020f, 16'h0210, 16'h0251, 16'h0252};
    end else begin
      corner = '{16'h0218, 16'h0219, 16'h02cc, 16'h0300};
    end
    old = warn ? 16'h0228 : 16'h0280;
    for (int i = 0; i < 10; i++) begin
      raw = (i < 4) ? corner[i] : 16'($urandom_range(16'h0500, 16'h0200));
      thr = warn ? fitThr(raw, 16'h0200, 206, 2, 14) : fitThr(raw, 16'h0200, 210, 5, 15);
      clr();
      u_host.xfer(1'b1, warn ? 8'h42 : 8'h40, raw, rd);
      clkN(4);
      look();
      `CHK("invalidFlag", thr == 9'h000, status.cmlInvalid)
      if (thr != 9'h000) old = raw;
      rdChk("limitRead", warn ? 8'h42 : 8'h40, old);
      if (thr != 9'h000) begin
        probe("thrOn", thr, warn);
        if (!warn && i % 2 == 0) begin
          convEnable <= 1'b0;
          probe("thrOff", offThr(thr), 1'b0);
          convEnable <= 1'b1;
        end
      end
    end
  endtask : sweep

  // Shutdown with a retry budget: hiccup length, then a quiet restart.
  task automatic retryRun(logic [2:0] rty, logic [2:0] dly, logic [19:0] ton);
    int c, nHic, nOk;
    nHic = 4 * ((dly == 3'h0) ? 1 : dly);
    nOk  = 5 + ((ton != 0) ? ton : 4) + 1;
    tonMaxCycles <= ton;
    u_host.xfer(1'b1, 8'h41, {8'h00, 2'b01, rty, dly}, rd);
    fire();
    look();
    c = 3;
    while (restartCount !== 3'h1 && c < 80) begin
      clkN(1);
      look();
      c++;
    end
    `CHK("hiccupLen", 1'b1, c >= nHic + 2 && c <= nHic + 6)
    c = 0;
    while (convShutdown !== 1'b0 && c < 80) begin
      clkN(1);
      look();
      c++;
    end
    `CHK("restartLen", 1'b1, c >= nOk - 1 && c <= nOk + 3)
    `CHK("countClear", 3'h0, restartCount)
    clkN(1);
  endtask : retryRun

  // Latch-off: stays off until conversion is commanded off.
  task automatic latchRun(logic [7:0] resp, bit refire);
    u_host.xfer(1'b1, 8'h41, {8'h00, resp}, rd);
    fire();
    if (refire) begin
      clkN(8);
      fire();
    end
    clkN(40);
    look();
    `CHK("latched", {1'b1, 2'(refire)}, {convShutdown, restartCount[1:0]})
    clkN(1);
    convEnable <= 1'b0;
    clkN(2);
    look();
    `CHK("release", 4'h0, {convShutdown, restartCount})
    clkN(1);
    convEnable <= 1'b1;
  endtask : latchRun

  task automatic end_sim();
    `CHK("linkAnswered", 1'b0, hostTimeout)
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Watchdog sized well beyond the expected run.
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  // Main sequence.
  initial begin
    {sys_rst, linkRst, convEnable, voutRelFormat, statusClear} = 5'b11010;
    {voutTarget, voutRatio, tonMaxCycles, riseCycles} = {16'h0400, 9'h000, 20'h0, 20'h4};
    error_cnt = 0;
    checks_done = 0;
    void'($urandom(55));
    clkN(4);
    sys_rst <= 1'b0;
    repeat (3) @(posedge linkClk);
    linkRst <= 1'b0;
    clkN(4);
    rdChk("faultRst", 8'h40, 16'h0280);
    rdChk("respRst", 8'h41, 16'h0080);
    rdChk("warnRst", 8'h42, 16'h0228);
    rdChk("unknown", 8'h55, 16'h0000);
    probe("offAtReset", 9'h104, 1'b0);
    $display("test reset done");
    convEnable <= 1'b1;
    u_host.xfer(1'b1, 8'h41, 16'h0000, rd);
    sweep(1'b0);
    sweep(1'b1);
    $display("test limits done");
    voutRelFormat <= 1'b0;
    voutTarget <= 16'h03e8;
    u_host.xfer(1'b1, 8'h40, 16'h04b0, rd);
    probe("absolute", 9'h0f0, 1'b0);
    voutTarget <= 16'h07d0;
    rdChk("absKept", 8'h40, 16'h04b0);
    probe("absRetarget", 9'h0f0, 1'b0);
    voutRelFormat <= 1'b1;
    clr();
    u_host.xfer(1'b1, 8'h41, 16'h00c7, rd);
    clkN(4);
    look();
    `CHK("respInvalid", 1'b1, status.cmlInvalid)
    rdChk("respKept", 8'h41, 16'h0000);
    $display("test format done");
    retryRun(3'h2, 3'h0, 20'h0);
    retryRun(3'h7, 3'h3, 20'h8);
    latchRun(8'h80, 1'b0);
    latchRun(8'h88, 1'b1);
    $display("test response done");
    end_sim();
  end
endmodule : vout_overvoltage_fault_monitor_tb_top
